// ==== common/fltmc_pkg.sv ====
package fltmc_pkg;
  localparam logic [7:0]  FLTMC_CMD_MODE        = 8'hD1;
  localparam logic [7:0]  FLTMC_CMD_SERIAL      = 8'h9E;
  localparam logic [7:0]  FLTMC_CMD_UNLOCK      = 8'hE0;
  localparam logic [7:0]  FLTMC_CMD_STATUS      = 8'hE1;
  localparam logic [7:0]  FLTMC_CMD_CTRL        = 8'hE2;
  localparam logic [7:0]  FLTMC_CMD_SUMMARY     = 8'hE3;
  localparam logic [7:0]  FLTMC_CMD_DETAIL      = 8'hE4;
  localparam int          FLTMC_BIT_SNAP        = 15;
  localparam int          FLTMC_BIT_ERASE       = 14;
  localparam int          FLTMC_BIT_DEC_HI      = 13;
  localparam int          FLTMC_BIT_DEC_LO      = 12;
  localparam int          FLTMC_BIT_RESET       = 11;
  localparam int          FLTMC_BIT_LOCK        = 10;
  localparam int          FLTMC_BIT_WRAP        = 9;
  localparam logic [15:0] FLTMC_MODE_WMASK      = 16'hFE00;
  localparam logic [15:0] FLTMC_MODE_RESET      = 16'h0000;
  localparam int          FLTMC_SUM_CML         = 1;
  localparam int          FLTMC_DET_FULL        = 0;
  localparam logic [7:0]  FLTMC_ERASE_BYTE      = 8'hFF;
  localparam int          FLTMC_CLK_MHZ         = 100;
  localparam int          FLTMC_SEQ_WIN_MS      = 8;
  localparam int          FLTMC_HOLD_MS         = 250;
  localparam int          FLTMC_SEQ_WIN_CYC     = FLTMC_SEQ_WIN_MS * FLTMC_CLK_MHZ * 1000;
  localparam int          FLTMC_HOLD_CYC        = FLTMC_HOLD_MS * FLTMC_CLK_MHZ * 1000;
  localparam int          FLTMC_LOG_DEPTH       = 16;
  localparam int          FLTMC_WRAP_FREE       = 2;
  localparam int          FLTMC_IRQ_SNAP_DONE   = 0;
  localparam int          FLTMC_IRQ_ERASE_DONE  = 1;
  localparam int          FLTMC_IRQ_FAIL        = 2;
  localparam int          FLTMC_IRQ_RESET       = 3;
  localparam int          FLTMC_IRQ_LOCK        = 4;
  localparam int          FLTMC_IRQ_W           = 5;
  localparam logic [7:0]  FLTMC_SW_STATUS       = 8'h00;
  localparam logic [7:0]  FLTMC_SW_MASK         = 8'h04;
  localparam logic [7:0]  FLTMC_SW_CMD          = 8'h08;
  localparam logic [7:0]  FLTMC_SW_DATA         = 8'h0C;
  localparam logic [7:0]  FLTMC_SW_RDATA        = 8'h10;
  localparam logic [7:0]  FLTMC_SW_HSTAT        = 8'h14;
  localparam logic [7:0]  FLTMC_SW_HOLD         = 8'h18;
endpackage

// ==== common/fltmc_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface fltmc_if;
  logic        wr;
  logic        rd;
  logic [7:0]  cmd;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        busy;
  modport dev  (input wr, rd, cmd, wdata, output rdata, busy);
  modport host (output wr, rd, cmd, wdata, input rdata, busy);
endinterface
`default_nettype wire

// ==== hdl/fltmc_seq_det.sv ====
`timescale 1ns/1ns
`default_nettype none
// Detects set, clear, set of one bit within a window
module fltmc_seq_det #(
  parameter int WIN_CYC = 800000
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic wr_i,
  input  wire logic bit_i,
  output logic      hit_o
);
  typedef enum logic [1:0] {IDLE, SET1, CLR} fltmc_seq_t;
  fltmc_seq_t  st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic        hit_nxt;

  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    hit_nxt = 1'b0;
    if (st_r != IDLE)
      cnt_nxt = cnt_r + 32'h1;
    if (st_r != IDLE && cnt_r >= WIN_CYC[31:0])
      st_nxt = IDLE;
    if (wr_i)
    begin
      case (st_r)
        IDLE:
        begin
          if (bit_i)
          begin
            st_nxt  = SET1;
            cnt_nxt = 32'h0;
          end
        end
        SET1:
        begin
          if (!bit_i && cnt_r < WIN_CYC[31:0])
            st_nxt = CLR;
          else if (bit_i)
            cnt_nxt = 32'h0;
        end
        CLR:
        begin
          if (bit_i && cnt_r < WIN_CYC[31:0])
          begin
            hit_nxt = 1'b1;
            st_nxt  = IDLE;
          end
        end
        default: st_nxt = IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r  <= IDLE;
      cnt_r <= 32'h0;
      hit_o <= 1'b0;
    end
    else
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      hit_o <= hit_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/fltmc_dev.sv ====
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// (RQ1) Host waits 250 ms after mode write
// (RQ2) Snapshot bit logs, then self-clears
// (RQ3) Failure sets summary flag, detail untouched
// (RQ4) Erase fills log with FFh, self-clears
// (RQ5) Erase halts monitoring; host stays quiet
// (RQ6) Decimation logs every 1st/2nd/4th/8th result
// (RQ7) Reset needs set-clear-set within 8 ms
// (RQ8) Lock needs set-clear-set within 8 ms
// (RQ9) Unlock clears the lock bit
// (RQ10) Wrap bit: stop or overwrite when full
// (RQ11) Overwrite frees two entries at once
// (RQ12) Full flag sets, clears after overwrite
// (RQ13) Password is upper four serial bytes
module fltmc_dev
  import fltmc_pkg::*;
#(
  parameter int DEPTH   = FLTMC_LOG_DEPTH,
  parameter int WIN_CYC = FLTMC_SEQ_WIN_CYC
) (
  input  wire logic  clock_i,
  input  wire logic  rst_n_i,
  fltmc_if.dev       bus,
  input  wire logic  adc_valid_i,
  input  wire logic [15:0] adc_data_i,
  input  wire logic  nv_fail_i,
  output logic       monitor_en_o,
  output logic       soft_reset_o,
  output logic       locked_o,
  output logic       log_full_o
);
  localparam int AW = $clog2(DEPTH);
  typedef enum logic [1:0] {D_IDLE, D_SNAP, D_ERASE} fltmc_dst_t;

  logic [15:0]   log_mem [DEPTH];
  logic [15:0]   mode_r, mode_nxt;
  logic [63:0]   serial_r, serial_nxt;
  logic [7:0]    sum_r, sum_nxt;
  logic [7:0]    det_r, det_nxt;
  logic [AW-1:0] wp_r, wp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic [2:0]    dec_r, dec_nxt;
  logic [AW-1:0] ep_r, ep_nxt;
  logic          lock_r, lock_nxt, rst_r, rst_nxt;
  logic [31:0]   rdata_r, rdata_nxt;
  fltmc_dst_t    st_r, st_nxt;
  logic          hit_rst, hit_lock, mode_wr, do_log, full, mem_we;
  logic [AW-1:0] mem_a;
  logic [15:0]   mem_d;

  assign mode_wr = bus.wr && bus.cmd == FLTMC_CMD_MODE;
  assign full    = cnt_r == (AW+1)'(DEPTH);

  fltmc_seq_det #(.WIN_CYC(WIN_CYC)) u_rst (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .wr_i    (mode_wr),
    .bit_i   (bus.wdata[FLTMC_BIT_RESET]),
    .hit_o   (hit_rst)                                   // [RQ7]
  );
  fltmc_seq_det #(.WIN_CYC(WIN_CYC)) u_lock (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .wr_i    (mode_wr),
    .bit_i   (bus.wdata[FLTMC_BIT_LOCK]),
    .hit_o   (hit_lock)                                  // [RQ8]
  );

  function automatic logic dec_take(input logic [1:0] sel, input logic [2:0] c);
    logic [2:0] m;
    m = 3'((4'h1 << sel) - 4'h1);
    return (c & m) == 3'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    mode_nxt   = mode_r;
    serial_nxt = serial_r;
    sum_nxt    = sum_r;
    det_nxt    = det_r;
    wp_nxt     = wp_r;
    cnt_nxt    = cnt_r;
    dec_nxt    = dec_r;
    ep_nxt     = ep_r;
    lock_nxt   = lock_r;
    rst_nxt    = hit_rst;
    st_nxt     = st_r;
    mem_we     = 1'b0;
    mem_a      = wp_r;
    mem_d      = adc_data_i;
    do_log     = 1'b0;
    rdata_nxt  = 32'h0;
    if (bus.wr)
    begin
      case (bus.cmd)
        FLTMC_CMD_MODE:   mode_nxt = bus.wdata[15:0] & FLTMC_MODE_WMASK;
        FLTMC_CMD_SERIAL: serial_nxt = {bus.wdata, serial_r[63:32]};
        FLTMC_CMD_UNLOCK:
          if (bus.wdata == serial_r[63:32])             // [RQ13]
          begin
            lock_nxt = 1'b0;
            mode_nxt[FLTMC_BIT_LOCK] = 1'b0;             // [RQ9]
          end
        FLTMC_CMD_SUMMARY: sum_nxt = sum_r & ~bus.wdata[7:0];
        default: ;
      endcase
    end
    if (hit_lock)
      lock_nxt = 1'b1;
    if (bus.rd)
    begin
      case (bus.cmd)
        FLTMC_CMD_MODE:    rdata_nxt = {16'h0, mode_r};
        FLTMC_CMD_SUMMARY: rdata_nxt = {24'h0, sum_r};
        FLTMC_CMD_DETAIL:  rdata_nxt = {24'h0, det_r};
        FLTMC_CMD_STATUS:  rdata_nxt = {29'h0, lock_r, full, st_r != D_IDLE};
        default:           rdata_nxt = 32'h0;
      endcase
    end
    case (st_r)
      D_IDLE:
      begin
        if (mode_r[FLTMC_BIT_ERASE])
        begin
          st_nxt = D_ERASE;
          ep_nxt = '0;
        end
        else if (mode_r[FLTMC_BIT_SNAP])
          st_nxt = D_SNAP;
        else if (adc_valid_i)
        begin
          dec_nxt = dec_r + 3'h1;
          do_log  = dec_take(mode_r[FLTMC_BIT_DEC_HI:FLTMC_BIT_DEC_LO], dec_r); // [RQ6]
        end
      end
      D_SNAP:
      begin
        do_log = 1'b1;                                   // [RQ2]
        if (nv_fail_i)
          sum_nxt[FLTMC_SUM_CML] = 1'b1;                 // [RQ3]
        mode_nxt[FLTMC_BIT_SNAP] = 1'b0;                 // [RQ2]
        st_nxt = D_IDLE;
      end
      D_ERASE:
      begin
        mem_we = 1'b1;                                   // [RQ5]
        mem_a  = ep_r;
        mem_d  = {FLTMC_ERASE_BYTE, FLTMC_ERASE_BYTE};   // [RQ4]
        ep_nxt = ep_r + 1'b1;
        if (ep_r == AW'(DEPTH - 1))
        begin
          if (nv_fail_i)
            sum_nxt[FLTMC_SUM_CML] = 1'b1;               // [RQ3]
          mode_nxt[FLTMC_BIT_ERASE] = 1'b0;              // [RQ4]
          wp_nxt  = '0;
          cnt_nxt = '0;
          det_nxt[FLTMC_DET_FULL] = 1'b0;
          st_nxt  = D_IDLE;
        end
      end
      default: st_nxt = D_IDLE;
    endcase
    if (do_log)
    begin
      if (!full)
      begin
        mem_we  = 1'b1;
        wp_nxt  = wp_r + 1'b1;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == (AW+1)'(DEPTH - 1))
          det_nxt[FLTMC_DET_FULL] = 1'b1;                // [RQ12]
      end
      else if (mode_r[FLTMC_BIT_WRAP])                   // [RQ10]
      begin
        // Two slots freed per overwrite, one reused now
        mem_we  = 1'b1;
        wp_nxt  = wp_r + 1'b1;
        cnt_nxt = cnt_r - (AW+1)'(FLTMC_WRAP_FREE - 1);  // [RQ11]
        det_nxt[FLTMC_DET_FULL] = 1'b0;                  // [RQ12]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i)
  begin
    if (mem_we)
      log_mem[mem_a] <= mem_d;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_r       <= FLTMC_MODE_RESET;
      serial_r     <= '0;
      sum_r        <= 8'h00;
      det_r        <= 8'h00;
      wp_r         <= '0;
      cnt_r        <= '0;
      dec_r        <= 3'h0;
      ep_r         <= '0;
      lock_r       <= 1'b0;
      rst_r        <= 1'b0;
      st_r         <= D_IDLE;
      rdata_r      <= 32'h0;
      monitor_en_o <= 1'b1;
      locked_o     <= 1'b0;
      log_full_o   <= 1'b0;
    end
    else
    begin
      mode_r       <= mode_nxt;
      serial_r     <= serial_nxt;
      sum_r        <= sum_nxt;
      det_r        <= det_nxt;
      wp_r         <= wp_nxt;
      cnt_r        <= cnt_nxt;
      dec_r        <= dec_nxt;
      ep_r         <= ep_nxt;
      lock_r       <= lock_nxt;
      rst_r        <= rst_nxt;
      st_r         <= st_nxt;
      rdata_r      <= rdata_nxt;
      monitor_en_o <= st_nxt != D_ERASE;                 // [RQ5]
      locked_o     <= lock_nxt;
      log_full_o   <= det_nxt[FLTMC_DET_FULL];
    end
  end

  assign soft_reset_o = rst_r;
  assign bus.rdata    = rdata_r;
  assign bus.busy     = st_r == D_ERASE;
endmodule
`default_nettype wire

// ==== hdl/fltmc_host.sv ====
`timescale 1ns/1ns
`default_nettype none
// Host end: software port in, one-cycle commands out
module fltmc_host
  import fltmc_pkg::*;
#(
  parameter int HOLD_CYC = FLTMC_HOLD_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  fltmc_if.host            bus,
  input  wire logic [7:0]  sw_addr_i,
  input  wire logic [31:0] sw_wdata_i,
  input  wire logic        sw_wr_i,
  input  wire logic        sw_rd_i,
  output logic [31:0]      sw_rdata_o,
  output logic             irq_o
);
  logic [7:0]           cmd_r, cmd_nxt;
  logic [31:0]          data_r, data_nxt, rd_r, rd_nxt, hold_r, hold_nxt;
  logic                 wr_r, wr_nxt, rdc_r, rdc_nxt, cap_r, cap_nxt;
  logic [FLTMC_IRQ_W-1:0] st_r, st_nxt, mask_r, mask_nxt;
  logic [31:0]          swr_nxt;
  logic                 quiet;

  // Host refuses commands during hold and device erase
  assign quiet = hold_r == 32'h0 && !bus.busy;           // [RQ1] [RQ5]

  always_comb
  begin
    cmd_nxt  = cmd_r;
    data_nxt = data_r;
    rd_nxt   = rd_r;
    wr_nxt   = 1'b0;
    rdc_nxt  = 1'b0;
    cap_nxt  = rdc_r;
    st_nxt   = st_r;
    mask_nxt = mask_r;
    hold_nxt = hold_r == 32'h0 ? 32'h0 : hold_r - 32'h1;
    swr_nxt  = 32'h0;
    if (cap_r)
      rd_nxt = bus.rdata;
    if (sw_wr_i)
    begin
      case (sw_addr_i)
        FLTMC_SW_STATUS: st_nxt = st_r & ~sw_wdata_i[FLTMC_IRQ_W-1:0];
        FLTMC_SW_MASK:   mask_nxt = sw_wdata_i[FLTMC_IRQ_W-1:0];
        FLTMC_SW_DATA:   data_nxt = sw_wdata_i;
        FLTMC_SW_CMD:
          if (quiet)
          begin
            cmd_nxt = sw_wdata_i[7:0];
            wr_nxt  = !sw_wdata_i[8];
            rdc_nxt = sw_wdata_i[8];
            if (!sw_wdata_i[8] && sw_wdata_i[7:0] == FLTMC_CMD_MODE)
              hold_nxt = HOLD_CYC;                       // [RQ1]
          end
        default: ;
      endcase
    end
    if (wr_r && cmd_r == FLTMC_CMD_MODE)
    begin
      st_nxt[FLTMC_IRQ_SNAP_DONE]  = st_nxt[FLTMC_IRQ_SNAP_DONE] | data_r[FLTMC_BIT_SNAP];
      st_nxt[FLTMC_IRQ_ERASE_DONE] = st_nxt[FLTMC_IRQ_ERASE_DONE] | data_r[FLTMC_BIT_ERASE];
    end
    if (sw_rd_i)
    begin
      case (sw_addr_i)
        FLTMC_SW_STATUS: swr_nxt = {27'h0, st_r};
        FLTMC_SW_MASK:   swr_nxt = {27'h0, mask_r};
        FLTMC_SW_RDATA:  swr_nxt = rd_r;
        FLTMC_SW_HSTAT:  swr_nxt = {31'h0, !quiet};
        FLTMC_SW_HOLD:   swr_nxt = hold_r;
        default:         swr_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmd_r      <= 8'h00;
      data_r     <= 32'h0;
      rd_r       <= 32'h0;
      hold_r     <= 32'h0;
      wr_r       <= 1'b0;
      rdc_r      <= 1'b0;
      cap_r      <= 1'b0;
      st_r       <= '0;
      mask_r     <= '0;
      sw_rdata_o <= 32'h0;
      irq_o      <= 1'b0;
    end
    else
    begin
      cmd_r      <= cmd_nxt;
      data_r     <= data_nxt;
      rd_r       <= rd_nxt;
      hold_r     <= hold_nxt;
      wr_r       <= wr_nxt;
      rdc_r      <= rdc_nxt;
      cap_r      <= cap_nxt;
      st_r       <= st_nxt;
      mask_r     <= mask_nxt;
      sw_rdata_o <= swr_nxt;
      irq_o      <= |(st_nxt & mask_nxt);
    end
  end

  assign bus.wr    = wr_r;
  assign bus.rd    = rdc_r;
  assign bus.cmd   = cmd_r;
  assign bus.wdata = data_r;
endmodule
`default_nettype wire

// ==== verification/fltmc_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module fltmc_sva
  import fltmc_pkg::*;
#(
  parameter int HOLD_CYC = FLTMC_HOLD_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [7:0]  cmd,
  input  wire logic [31:0] wdata,
  input  wire logic        busy,
  input  wire logic        monitor_en_o,
  input  wire logic        soft_reset_o,
  input  wire logic        locked_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] quiet_r;
  logic [31:0] quiet_nxt;
  logic        mode_wr;
  logic        unlk_wr;
  assign mode_wr = wr && (cmd == FLTMC_CMD_MODE);
  assign unlk_wr = wr && (cmd == FLTMC_CMD_UNLOCK);
  // Counts the quiet span owed after a mode write
  always_comb
  begin
    quiet_nxt = (quiet_r != 32'h0) ? quiet_r - 32'h1 : 32'h0;
    if (mode_wr)
    begin
      quiet_nxt = 32'(HOLD_CYC - 1);
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      quiet_r <= 32'h0;
    end
    else
    begin
      quiet_r <= quiet_nxt;
    end
  end
  sequence s_erase_wr;
    mode_wr ##0 wdata[FLTMC_BIT_ERASE];
  endsequence
  sequence s_rst_wr;
    mode_wr ##0 wdata[FLTMC_BIT_RESET];
  endsequence
  ////////////////////////////////////////
  chk_hold_quiet: assert property (quiet_r != 32'h0 |-> !wr && !rd)
    else $error("bus command inside hold span");
  chk_busy_quiet: assert property (busy |-> !wr && !rd)
    else $error("bus command during erase");
  chk_erase_halt: assert property (s_erase_wr |-> ##[1:2] (busy && !monitor_en_o))
    else $error("erase did not halt monitoring");
  chk_busy_nomon: assert property (busy |-> !monitor_en_o)
    else $error("monitoring while erasing");
  chk_busy_ends: assert property ($rose(busy) |-> ##[1:1000] !busy)
    else $error("erase never finished");
  chk_busy_cause: assert property ($rose(busy) |-> $past(wdata[FLTMC_BIT_ERASE] && mode_wr)
    || $past(wdata[FLTMC_BIT_ERASE] && mode_wr, 2))
    else $error("erase without request");
  chk_rst_pulse: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset longer than one cycle");
  chk_rst_cause: assert property (soft_reset_o |-> $past(wdata[FLTMC_BIT_RESET] && mode_wr)
    || $past(wdata[FLTMC_BIT_RESET] && mode_wr, 2))
    else $error("soft reset without set write");
  chk_lock_cause: assert property ($rose(locked_o) |-> $past(wdata[FLTMC_BIT_LOCK] && mode_wr)
    || $past(wdata[FLTMC_BIT_LOCK] && mode_wr, 2))
    else $error("lock without set write");
  chk_unlock_cause: assert property ($fell(locked_o) |-> $past(unlk_wr) || $past(unlk_wr, 2))
    else $error("unlock without unlock command");
  cov_reset: cover property (s_rst_wr ##[1:2] soft_reset_o);
endmodule
`default_nettype wire

// ==== verification/fltmc_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module fltmc_test
  import fltmc_pkg::*;
;
  localparam int HOLD = 20;
  localparam int WIN  = 80;
  localparam int DEP  = 8;
  logic        clock_i;
  logic        rst_n_i;
  logic        adc_valid_i;
  logic [15:0] adc_data_i;
  logic        nv_fail_i;
  logic        monitor_en_o;
  logic        soft_reset_o;
  logic        locked_o;
  logic        log_full_o;
  logic [7:0]  sw_addr_i;
  logic [31:0] sw_wdata_i;
  logic        sw_wr_i;
  logic        sw_rd_i;
  logic [31:0] sw_rdata_o;
  logic        irq_o;
  logic [31:0] v;
  logic [31:0] det;
  int          num_errors = 0;
  int          checked = 0;
  int          resets_seen = 0;
  fltmc_if bus_if();
  fltmc_dev #(.DEPTH(DEP), .WIN_CYC(WIN)) u_fltmc_dev (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .bus(bus_if), .adc_valid_i(adc_valid_i), .adc_data_i(adc_data_i), .nv_fail_i(nv_fail_i),
    .monitor_en_o(monitor_en_o), .soft_reset_o(soft_reset_o), .locked_o(locked_o),
    .log_full_o(log_full_o));
  fltmc_host #(.HOLD_CYC(HOLD)) u_fltmc_host (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus(bus_if),
    .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
    .sw_rdata_o(sw_rdata_o), .irq_o(irq_o));
  fltmc_sva #(.HOLD_CYC(HOLD)) u_fltmc_sva (.clock_i(clock_i), .rst_n_i(rst_n_i), .wr(bus_if.wr),
    .rd(bus_if.rd), .cmd(bus_if.cmd), .wdata(bus_if.wdata), .busy(bus_if.busy),
    .monitor_en_o(monitor_en_o), .soft_reset_o(soft_reset_o), .locked_o(locked_o));
  ////////////////////////////////////////
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    if (soft_reset_o === 1'b1)
    begin
      resets_seen <= resets_seen + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobe dropped then one idle edge, so calls never collide
  task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
    sw_addr_i  <= a;
    sw_wdata_i <= d;
    sw_wr_i    <= 1'b1;
    @(posedge clock_i);
    sw_wr_i    <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
    sw_addr_i <= a;
    sw_rd_i   <= 1'b1;
    @(posedge clock_i);
    sw_rd_i   <= 1'b0;
    @(posedge clock_i);
    d = sw_rdata_o;
  endtask
  task automatic dev_wr(input logic [7:0] c, input logic [31:0] d);
    sw_wr(FLTMC_SW_DATA, d);
    sw_wr(FLTMC_SW_CMD, {24'h0, c});
    repeat (HOLD) @(posedge clock_i);
    for (int i = 0; i < 500 && bus_if.busy !== 1'b0; i++) @(posedge clock_i);
    chk({31'h0, bus_if.busy}, 32'h0);
  endtask
  task automatic dev_rd(input logic [7:0] c, output logic [31:0] d);
    sw_wr(FLTMC_SW_CMD, {23'h0, 1'b1, c});
    repeat (3) @(posedge clock_i);
    sw_rd(FLTMC_SW_RDATA, d);
  endtask
  task automatic adc(input int n);
    for (int i = 0; i < n; i++)
    begin
      adc_valid_i <= 1'b1;
      adc_data_i  <= 16'(i);
      @(posedge clock_i);
      adc_valid_i <= 1'b0;
      @(posedge clock_i);
    end
    repeat (2) @(posedge clock_i);
  endtask
  ////////////////////////////////////////
  task automatic t_snap();
    dev_rd(FLTMC_CMD_MODE, v);
    chk(v, 32'(FLTMC_MODE_RESET));
    dev_rd(FLTMC_CMD_DETAIL, det);
    sw_wr(FLTMC_SW_DATA, 32'h00008000);
    sw_wr(FLTMC_SW_CMD, {24'h0, FLTMC_CMD_MODE});
    sw_rd(FLTMC_SW_HSTAT, v);
    chk(v, 32'h1);
    // Refused inside the hold span; the checker sees any leak on the link
    sw_wr(FLTMC_SW_CMD, {23'h0, 1'b1, FLTMC_CMD_MODE});
    repeat (HOLD) @(posedge clock_i);
    sw_rd(FLTMC_SW_HSTAT, v);
    chk(v, 32'h0);
    dev_rd(FLTMC_CMD_MODE, v);
    chk(v, 32'h0);
    sw_rd(FLTMC_SW_STATUS, v);
    chk(v & 32'h1, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    sw_wr(FLTMC_SW_MASK, 32'h0000001F);
    chk({31'h0, irq_o}, 32'h1);
    sw_wr(FLTMC_SW_STATUS, 32'h0000001F);
    chk({31'h0, irq_o}, 32'h0);
    sw_wr(FLTMC_SW_MASK, 32'h0);
    sw_rd(8'hFC, v);
    chk(v, 32'h0);
    nv_fail_i <= 1'b1;
    dev_wr(FLTMC_CMD_MODE, 32'h00008000);
    dev_rd(FLTMC_CMD_SUMMARY, v);
    chk(v & 32'h2, 32'h2);
    dev_rd(FLTMC_CMD_DETAIL, v);
    chk(v, det);
    dev_wr(FLTMC_CMD_SUMMARY, 32'h2);
    dev_rd(FLTMC_CMD_SUMMARY, v);
    chk(v & 32'h2, 32'h0);
    dev_wr(FLTMC_CMD_MODE, 32'h00004000);
    dev_rd(FLTMC_CMD_SUMMARY, v);
    chk(v & 32'h2, 32'h2);
    dev_rd(FLTMC_CMD_DETAIL, v);
    chk(v, det);
    nv_fail_i <= 1'b0;
  endtask
  // Full only after DEP logged results, whatever the decimation phase
  task automatic t_fill(input int d, input logic [15:0] mode);
    dev_wr(FLTMC_CMD_MODE, 32'h00004000);
    dev_rd(FLTMC_CMD_MODE, v);
    chk(v, 32'h0);
    chk({31'h0, log_full_o}, 32'h0);
    dev_wr(FLTMC_CMD_MODE, {16'h0, mode});
    adc((DEP - 1) << d);
    chk({31'h0, log_full_o}, 32'h0);
    adc(1 << d);
    chk({31'h0, log_full_o}, 32'h1);
    adc(1);
    chk({31'h0, log_full_o}, {31'h0, !mode[FLTMC_BIT_WRAP]});
    adc(1);
    chk({31'h0, log_full_o}, 32'h1);
  endtask
  task automatic t_lock();
    dev_wr(FLTMC_CMD_SERIAL, 32'h11111111);
    dev_wr(FLTMC_CMD_SERIAL, 32'h5A5A0001);
    dev_wr(FLTMC_CMD_MODE, 32'h00000400);
    dev_wr(FLTMC_CMD_MODE, 32'h0);
    dev_wr(FLTMC_CMD_MODE, 32'h00000400);
    chk({31'h0, locked_o}, 32'h1);
    dev_rd(FLTMC_CMD_STATUS, v);
    chk(v, 32'h6);
    dev_wr(FLTMC_CMD_UNLOCK, 32'h11111111);
    chk({31'h0, locked_o}, 32'h1);
    dev_wr(FLTMC_CMD_UNLOCK, 32'h5A5A0001);
    chk({31'h0, locked_o}, 32'h0);
    dev_rd(FLTMC_CMD_MODE, v);
    chk(v, 32'h0);
  endtask
  task automatic t_reset();
    dev_wr(FLTMC_CMD_MODE, 32'h00000800);
    dev_wr(FLTMC_CMD_MODE, 32'h0);
    repeat (40) @(posedge clock_i);
    dev_wr(FLTMC_CMD_MODE, 32'h00000800);
    chk(32'(resets_seen), 32'h0);
    dev_wr(FLTMC_CMD_MODE, 32'h0);
    dev_wr(FLTMC_CMD_MODE, 32'h00000800);
    chk(32'(resets_seen), 32'h1);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial
  begin
    #800000;
    num_errors++;
    summarize();
  end
  initial
  begin
    rst_n_i = 1'b0;
    adc_valid_i = 1'b0;
    adc_data_i = 16'h0000;
    nv_fail_i = 1'b0;
    sw_addr_i = 8'h00;
    sw_wdata_i = 32'h0;
    sw_wr_i = 1'b0;
    sw_rd_i = 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    chk({31'h0, monitor_en_o}, 32'h1);
    t_snap();
    for (int d = 0; d < 4; d++) t_fill(d, 16'(d << FLTMC_BIT_DEC_LO));
    t_fill(0, 16'h0200);
    t_lock();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
